// *** rtl/angle_output_port.sv ***
`timescale 1ns/1ps
module angle_output_port #(
  parameter int POS_W      = angle_port_pkg::POS_W,
  parameter int FIFO_DEPTH = angle_port_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             CLOCK,
  input  wire logic             RST_N,
  // angle samples from the sensing front end
  input  wire logic             ANGLE_VALID,
  output logic                  ANGLE_READY,
  input  wire logic [POS_W-1:0] ANGLE,
  // parallel port
  input  wire logic             HOLD,
  output logic      [POS_W-1:0] PAR_POS,
  // serial port
  input  wire logic             SER_CLK,
  output logic                  SER_DATA
);
  localparam int CW = $clog2(angle_port_pkg::MONOFLOP_CYC + 1);

  typedef struct packed {
    logic [1:0]       hold_s;
    logic [1:0]       sclk_s;
    logic             sclk_prev;
    logic [POS_W-1:0] live;
    logic [POS_W-1:0] par;
    logic [POS_W-1:0] shreg;
    logic             busy;
    logic [CW-1:0]    idle;
    logic             sdo;
  } port_s;

  port_s            s_q, s_d;
  logic             f_valid;
  logic [POS_W-1:0] f_data;
  logic             sclk_fall, sclk_rise;

  // buffering absorbs bursts from the front end; drains every cycle
  angle_fifo #(.W(POS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .CLOCK     (CLOCK),
    .RST_N     (RST_N),
    .IN_VALID  (ANGLE_VALID),
    .IN_READY  (ANGLE_READY),
    .IN_DATA   (ANGLE),
    .OUT_VALID (f_valid),
    .OUT_READY (1'b1),
    .OUT_DATA  (f_data)
  );

  assign sclk_fall = s_q.sclk_prev && !s_q.sclk_s[1];
  assign sclk_rise = !s_q.sclk_prev && s_q.sclk_s[1];

  always_comb begin
    s_d           = s_q;
    s_d.hold_s    = {s_q.hold_s[0], HOLD};
    s_d.sclk_s    = {s_q.sclk_s[0], SER_CLK};
    s_d.sclk_prev = s_q.sclk_s[1];
    // front end already codes clockwise as increasing
    if (f_valid) s_d.live = f_data;
    if (!s_q.hold_s[1]) s_d.par = s_d.live;
    if (!s_q.busy) begin
      if (sclk_fall) begin
        // first falling edge latches the word; msb leads
        s_d.shreg = s_q.live;
        s_d.busy  = 1'b1;
        s_d.idle  = '0;
        s_d.sdo   = s_q.live[POS_W-1];
      end else begin
        s_d.sdo = 1'b1;
      end
    end else begin
      if (sclk_rise) begin
        s_d.shreg = {s_q.shreg[POS_W-2:0], 1'b0};
        s_d.sdo   = s_q.shreg[POS_W-2];
      end
      // clock idle counts toward frame end; any edge restarts it
      if (sclk_fall || sclk_rise) s_d.idle = '0;
      else if (s_q.idle == CW'(angle_port_pkg::MONOFLOP_CYC)) begin
        s_d.busy = 1'b0;
        s_d.sdo  = 1'b1;
      end else s_d.idle = s_q.idle + CW'(1);
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_q           <= '0;
      s_q.sclk_s    <= 2'b11;
      s_q.sclk_prev <= 1'b1;
      s_q.sdo       <= 1'b1;
    end else s_q <= s_d;
  end

  assign PAR_POS  = s_q.par;
  assign SER_DATA = s_q.sdo;

  property p_hold_freeze;
    @(posedge CLOCK) disable iff (!RST_N)
      s_q.hold_s[1] |=> $stable(PAR_POS);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("parallel moved while held");

  property p_follow;
    @(posedge CLOCK) disable iff (!RST_N)
      (!s_q.hold_s[1] && f_valid) |=> (PAR_POS == $past(f_data));
  endproperty
  a_follow: assert property (p_follow) else $error("parallel not following");

  property p_load;
    @(posedge CLOCK) disable iff (!RST_N)
      (!s_q.busy && sclk_fall) |=> (s_q.busy && SER_DATA == $past(s_q.live[POS_W-1]));
  endproperty
  a_load: assert property (p_load) else $error("word not loaded");

  sequence s_rise_in_frame;
    s_q.busy && sclk_rise;
  endsequence
  property p_shift;
    @(posedge CLOCK) disable iff (!RST_N)
      s_rise_in_frame |=> (SER_DATA == $past(s_q.shreg[POS_W-2]));
  endproperty
  a_shift: assert property (p_shift) else $error("bad shifted bit");

  property p_idle_high;
    @(posedge CLOCK) disable iff (!RST_N)
      !s_q.busy |-> SER_DATA;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("data low outside frame");

  property p_timeout;
    @(posedge CLOCK) disable iff (!RST_N)
      (s_q.busy && s_q.idle == CW'(angle_port_pkg::MONOFLOP_CYC) && !sclk_fall && !sclk_rise)
        |=> !s_q.busy;
  endproperty
  a_timeout: assert property (p_timeout) else $error("frame did not end");

  property p_no_early_end;
    @(posedge CLOCK) disable iff (!RST_N)
      (s_q.busy && s_q.idle < CW'(angle_port_pkg::MONOFLOP_CYC)) |=> s_q.busy;
  endproperty
  a_no_early_end: assert property (p_no_early_end) else $error("frame ended early");

  property p_same_word;
    @(posedge CLOCK) disable iff (!RST_N)
      (!s_q.busy && sclk_fall && !s_q.hold_s[1]) |=> (s_q.shreg == $past(s_q.live));
  endproperty
  a_same_word: assert property (p_same_word) else $error("serial word differs");

  // while hold is off, serial and parallel paths must agree on the word latched at frame start
  property p_par_ser_match;
    @(posedge CLOCK) disable iff (!RST_N)
      (!s_q.busy && sclk_fall && !$past(s_q.hold_s[1])) |=> (s_q.shreg == $past(PAR_POS));
  endproperty
  a_par_ser_match: assert property (p_par_ser_match) else $error("words differ");

  // pin edges show up two cycles later, once through the two synchroniser stages
  sequence s_pin_fall;
    SER_CLK ##1 !SER_CLK;
  endsequence
  property p_pin_fall;
    @(posedge CLOCK) disable iff (!RST_N)
      s_pin_fall |-> ##2 sclk_fall;
  endproperty
  a_pin_fall: assert property (p_pin_fall) else $error("clock fall missed");

  sequence s_pin_rise;
    !SER_CLK ##1 SER_CLK;
  endsequence
  property p_pin_rise;
    @(posedge CLOCK) disable iff (!RST_N)
      s_pin_rise |-> ##2 sclk_rise;
  endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("clock rise missed");

  property p_frame_start;
    @(posedge CLOCK) disable iff (!RST_N)
      (s_pin_fall ##2 !s_q.busy) |=> (s_q.busy && SER_DATA == $past(s_q.live[POS_W-1]));
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start wrong");

  property p_quiet;
    @(posedge CLOCK) disable iff (!RST_N)
      (!s_q.busy && !sclk_fall) |=> !s_q.busy;
  endproperty
  a_quiet: assert property (p_quiet) else $error("frame opened without clock");

  // a data bit may only move on a rising edge or at frame end
  property p_data_stands;
    @(posedge CLOCK) disable iff (!RST_N)
      (s_q.busy && !sclk_rise) |=> ($stable(SER_DATA) || !s_q.busy);
  endproperty
  a_data_stands: assert property (p_data_stands) else $error("data moved off edge");

  property p_idle_bound;
    @(posedge CLOCK) disable iff (!RST_N)
      s_q.idle <= CW'(angle_port_pkg::MONOFLOP_CYC);
  endproperty
  a_idle_bound: assert property (p_idle_bound) else $error("idle count overran");

  // the pin needs three clean samples before the freeze is sure to bite
  sequence s_hold_settled;
    HOLD [*3];
  endsequence
  property p_hold_pin;
    @(posedge CLOCK) disable iff (!RST_N)
      s_hold_settled |=> $stable(PAR_POS);
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("hold pin ignored");

  property p_release_pin;
    @(posedge CLOCK) disable iff (!RST_N)
      ((!HOLD) [*3] ##0 f_valid) |=> (PAR_POS == $past(f_data));
  endproperty
  a_release_pin: assert property (p_release_pin) else $error("released port stuck");

  // drain never stalls, so each accepted sample reaches the live word two edges on
  property p_live_path;
    @(posedge CLOCK) disable iff (!RST_N)
      (ANGLE_VALID && ANGLE_READY) |-> ##2 (s_q.live == $past(ANGLE, 2));
  endproperty
  a_live_path: assert property (p_live_path) else $error("sample lost on the way");
endmodule : angle_output_port

// *** shared/angle_port_pkg.sv ***
package angle_port_pkg;
  localparam int          POS_W          = 9;
  localparam int          POS_STEPS      = 512;
  localparam int          CLK_HZ         = 25000000;
  localparam int          MONOFLOP_NS    = 25000;
  localparam int          MONOFLOP_CYC   = (MONOFLOP_NS / 40);
  localparam int          FIFO_DEPTH     = 8;
  localparam int          SYNC_STAGES    = 2;
  localparam logic [8:0]  POS_RESET      = 9'h000;
  localparam logic [8:0]  POS_STEP       = 9'h001;

  typedef struct packed {
    logic       valid;
    logic [8:0] pos;
  } sample_s;
endpackage : angle_port_pkg

// *** rtl/angle_fifo.sv ***
`timescale 1ns/1ps
module angle_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         CLOCK,
  input  wire logic         RST_N,
  // fill side
  input  wire logic         IN_VALID,
  output logic              IN_READY,
  input  wire logic [W-1:0] IN_DATA,
  // drain side
  output logic              OUT_VALID,
  input  wire logic         OUT_READY,
  output logic      [W-1:0] OUT_DATA
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } fifo_s;
  fifo_s         s_q, s_d;
  logic [W-1:0]  mem [DEPTH];
  logic          push, pop;

  assign IN_READY  = (s_q.cnt != (AW+1)'(DEPTH));
  assign OUT_VALID = (s_q.cnt != '0);
  assign OUT_DATA  = mem[s_q.rd];
  assign push      = IN_VALID && IN_READY;
  assign pop       = OUT_VALID && OUT_READY;

  always_comb begin
    s_d = s_q;
    if (push) s_d.wr = s_q.wr + AW'(1);
    if (pop) s_d.rd = s_q.rd + AW'(1);
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) s_q <= '0;
    else s_q <= s_d;
  end

  // storage has no reset: contents are never read while empty
  always_ff @(posedge CLOCK) begin
    if (push) mem[s_q.wr] <= IN_DATA;
  end
endmodule : angle_fifo

// *** tb/angle_receiver.sv ***
`timescale 1ns/1ps
module angle_receiver #(
  parameter int HALF_NS = 160
) (
  // serial link
  output logic      SER_CLK,
  input  wire logic SER_DATA
);
  // clock stands high outside frames
  initial SER_CLK = 1'h1;
  // first fall loads the word; each bit is taken at the end of its low half
  task automatic read_frame(output logic [8:0] w);
    for (int i = 8; i >= 0; i--) begin
      SER_CLK = 1'h0;
      // no cable in the bench: the period only has to clear the synchroniser
      #(HALF_NS);
      w[i] = SER_DATA;
      SER_CLK = 1'h1;
      #(HALF_NS);
    end
    #(28000);
  endtask : read_frame
endmodule : angle_receiver

// *** tb/angle_output_port_tb.sv ***
`timescale 1ns/1ps
module angle_output_port_tb;
  logic       CLOCK, RST_N, ANGLE_VALID, ANGLE_READY, HOLD, SER_CLK, SER_DATA;
  logic [8:0] ANGLE, PAR_POS, last_par, cur, w, old;
  logic [8:0] exp_q[$];
  logic [8:0] vals[4];
  int         n_fail, n_tests, cyc;
  integer     seed;
  angle_output_port u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .ANGLE_VALID(ANGLE_VALID),
    .ANGLE_READY(ANGLE_READY), .ANGLE(ANGLE), .HOLD(HOLD), .PAR_POS(PAR_POS),
    .SER_CLK(SER_CLK), .SER_DATA(SER_DATA));
  angle_receiver u_rx (.SER_CLK(SER_CLK), .SER_DATA(SER_DATA));
  initial begin
    CLOCK = 1'h0;
    forever #20 CLOCK = ~CLOCK;
  end
  task automatic check9(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : check9
  task automatic check1(input string nm, input logic e, input logic g);
    check9(nm, {8'h00, e}, {8'h00, g});
  endtask : check1
  task automatic finish_test();
    $display("compared %0d, mismatched %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  // valid stays high across calls, so samples go back to back
  task automatic send(input logic [8:0] v, input bit expect_it);
    ANGLE = v;
    if (expect_it && v !== cur) exp_q.push_back(v);
    if (expect_it) cur = v;
    @(negedge CLOCK);
  endtask : send
  // queue monitor: each change of the parallel word consumes one note; a change with none queued is checked as frozen
  always @(negedge CLOCK) if (RST_N && PAR_POS !== last_par) begin
    old = last_par;
    last_par = PAR_POS;
    if (exp_q.size() == 0) check9("par_pos frozen", old, PAR_POS);
    else check9("par_pos", exp_q.pop_front(), PAR_POS);
  end
  // ceiling: about 3450 cycles of tests plus margin
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    int st;
    seed = 32'h3BE4;
    {RST_N, ANGLE_VALID, HOLD, ANGLE, cur, last_par} = '0;
    repeat (8) @(negedge CLOCK);
    check9("par_pos reset", 9'h000, PAR_POS);
    check1("ser_data reset", 1'h1, SER_DATA);
    check1("ready reset", 1'h1, ANGLE_READY);
    repeat (8) @(negedge CLOCK);
    RST_N = 1'h1;
    $display("reset test done");
    ANGLE_VALID = 1'h1;
    // random walk both ways, wraps through 511/0
    for (int i = 0; i < 300; i++) begin
      st = ($random(seed) & 3) + 1;
      send(($random(seed) & 8) ? cur + 9'(st) : cur - 9'(st), 1'b1);
    end
    repeat (4) @(negedge CLOCK);
    $display("stream test done");
    HOLD = 1'h1;
    repeat (5) @(negedge CLOCK);
    for (int i = 0; i < 9; i++) send(9'($random(seed)), 1'b0);
    send(cur ^ 9'h155, 1'b0);
    repeat (4) @(negedge CLOCK);
    check9("par_pos held", cur, PAR_POS);
    HOLD = 1'h0;
    send(cur ^ 9'h155, 1'b1);
    repeat (6) @(negedge CLOCK);
    $display("hold test done");
    vals = '{9'h1FF, 9'h100, 9'h001, 9'($random(seed))};
    foreach (vals[k]) begin
      send(vals[k], 1'b1);
      repeat (4) @(negedge CLOCK);
      u_rx.read_frame(w);
      check9("serial word", vals[k], w);
      check1("idle level", 1'h1, SER_DATA);
    end
    $display("serial test done");
    finish_test();
  end
endmodule : angle_output_port_tb
